// ==== aqst_pkg.sv ====
// Package with constants and types of the queue scan and trigger controller.
package aqst_pkg;

  // Operating modes of a queue.
  typedef enum logic [2:0] {
    AQST_MODE_DISABLED = 3'h0,
    AQST_MODE_SW_SINGLE = 3'h1,
    AQST_MODE_EXT_SINGLE = 3'h2,
    AQST_MODE_TMR_SINGLE = 3'h3,
    AQST_MODE_SW_CONT = 3'h4,
    AQST_MODE_EXT_CONT = 3'h5,
    AQST_MODE_TMR_CONT = 3'h6,
    AQST_MODE_RESERVED = 3'h7
  } aqst_mode_e;

  // Queue status as reported to software.
  typedef enum logic [2:0] {
    AQST_ST_IDLE = 3'h0,
    AQST_ST_ACTIVE = 3'h1,
    AQST_ST_PAUSED = 3'h2,
    AQST_ST_SUSPENDED = 3'h3,
    AQST_ST_PENDING = 3'h4
  } aqst_state_e;

  // Sequencer status for one queue.
  typedef struct packed {
    logic active;
    logic paused;
    logic pause_flag;
    logic complete_flag;
    logic overrun_flag;
  } aqst_qstat_s;

  // Register byte addresses.
  localparam logic [7:0] AQST_OFF_CTRL1 = 8'h00;
  localparam logic [7:0] AQST_OFF_CTRL2 = 8'h04;
  localparam logic [7:0] AQST_OFF_STATUS = 8'h08;
  localparam logic [7:0] AQST_OFF_PRESC = 8'h0C;
  localparam logic [7:0] AQST_OFF_CCW1 = 8'h10;
  localparam logic [7:0] AQST_OFF_CCW2 = 8'h14;

  // Control register fields.
  localparam int AQST_CTRL_MODE_LSB = 0;
  localparam int AQST_CTRL_EDGE_BIT = 3;
  localparam int AQST_CTRL_SSE_BIT = 4;
  localparam int AQST_CTRL_RATE_LSB = 8;

  // Command word fields: channel in the low six bits, pause bit above.
  localparam logic [5:0] AQST_EOQ_CHANNEL = 6'h3F;
  localparam int AQST_CCW_PAUSE_BIT = 6;

  // Timer interval range, expressed as powers of two of conversion clocks.
  localparam int AQST_TMR_MIN_EXP = 7;
  localparam int AQST_TMR_MAX_EXP = 17;
  localparam int AQST_TMR_BITS = 17;
  // Stall at a pause in software continuous mode, in conversion clocks.
  localparam logic [1:0] AQST_SWC_PAUSE_QCLKS = 2'h2;
  // Conversion clock divider reset value (system clocks per conversion clock, minus one).
  localparam logic [7:0] AQST_PRESC_RESET = 8'h0F;
  // Length of one conversion, in conversion clocks.
  localparam logic [4:0] AQST_CONV_QCLKS = 5'h12;
  localparam logic [31:0] AQST_RESET_CTRL = 32'h0000_0000;

endpackage : aqst_pkg

// ==== aqst_top.sv ====
// Queue scan mode and trigger controller with an AXI4-Lite register slave.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aqst_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External trigger pins.
  input wire logic ext_trig1,
  input wire logic ext_trig2,
  // Conversion sequencer.
  output logic [1:0] conv_start,
  output logic [5:0] conv_channel,
  output logic [1:0] conv_abort,
  output logic [5:0] ccw_index1,
  output logic [5:0] ccw_index2
);

  // Register file.
  logic [31:0] ctrl1;
  logic [31:0] ctrl2;
  logic [7:0] presc;
  logic [6:0] ccw_word [2];
  logic [5:0] ccw_len [2];
  logic [1:0] sse;
  logic [1:0] mode_wr;

  // AXI write channel holding registers.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic do_write;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bresp = 2'h0;

  logic [7:0] wsel;
  assign wsel = {aw_addr[7:2], 2'h0};

  // Registers written by software; the enable bit is a write-only strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1 <= aqst_pkg::AQST_RESET_CTRL;
      ctrl2 <= aqst_pkg::AQST_RESET_CTRL;
      presc <= aqst_pkg::AQST_PRESC_RESET;
      ccw_word[0] <= 7'h00;
      ccw_word[1] <= 7'h00;
      ccw_len[0] <= 6'h00;
      ccw_len[1] <= 6'h00;
      sse <= 2'h0;
      mode_wr <= 2'h0;
    end else begin
      sse <= 2'h0;
      mode_wr <= 2'h0;
      if (do_write) begin
        case (wsel)
          aqst_pkg::AQST_OFF_CTRL1: begin
            ctrl1 <= w_data;
            sse[0] <= w_data[aqst_pkg::AQST_CTRL_SSE_BIT];
            mode_wr[0] <= w_data[2:0] != ctrl1[2:0];
          end
          aqst_pkg::AQST_OFF_CTRL2: begin
            ctrl2 <= w_data;
            sse[1] <= w_data[aqst_pkg::AQST_CTRL_SSE_BIT];
            mode_wr[1] <= w_data[2:0] != ctrl2[2:0];
          end
          aqst_pkg::AQST_OFF_PRESC: presc <= w_data[7:0];
          aqst_pkg::AQST_OFF_CCW1: begin
            ccw_word[0] <= w_data[6:0];
            ccw_len[0] <= w_data[13:8];
          end
          aqst_pkg::AQST_OFF_CCW2: begin
            ccw_word[1] <= w_data[6:0];
            ccw_len[1] <= w_data[13:8];
          end
          default: ;
        endcase
      end
    end
  end

  // Conversion clock enable from the divider.
  logic [7:0] div_cnt;
  logic conversion_clock_en;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 8'h00;
      conversion_clock_en <= 1'b0;
    end else begin
      conversion_clock_en <= div_cnt == presc;
      div_cnt <= (div_cnt == presc) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // Trigger pin synchronisers and edge detection.
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] pin_lvl;
  logic [1:0] ext_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      pin_lvl <= 2'h0;
    end else begin
      sync1 <= {sync1[1:0], ext_trig1};
      sync2 <= {sync2[1:0], ext_trig2};
      if (sync1[1] == sync1[2]) pin_lvl[0] <= sync1[2];
      if (sync2[1] == sync2[2]) pin_lvl[1] <= sync2[2];
    end
  end
  // A new level counts only once the last two stages agree, so a slow or bouncy pin
  // cannot produce two edges; the edge bit names the level that is entered.
  assign ext_edge[0] = sync1[1] == sync1[2] && sync1[2] != pin_lvl[0]
    && sync1[2] == ctrl1[aqst_pkg::AQST_CTRL_EDGE_BIT];
  assign ext_edge[1] = sync2[1] == sync2[2] && sync2[2] != pin_lvl[1]
    && sync2[2] == ctrl2[aqst_pkg::AQST_CTRL_EDGE_BIT];

  // Modes.
  aqst_pkg::aqst_mode_e mode [2];
  assign mode[0] = aqst_pkg::aqst_mode_e'(ctrl1[2:0]);
  assign mode[1] = aqst_pkg::aqst_mode_e'(ctrl2[2:0]);
  logic tmr_mode;
  assign tmr_mode = mode[1] == aqst_pkg::AQST_MODE_TMR_SINGLE
    || mode[1] == aqst_pkg::AQST_MODE_TMR_CONT;

  // Internal single-scan enable, queue execution state.
  logic [1:0] armed;
  logic [1:0] active;
  logic [1:0] paused;
  logic [1:0] pend;
  logic q2_susp;
  logic [1:0] overrun;
  logic [1:0] pause_flag;
  logic [1:0] comp_flag;
  logic [5:0] idx [2];
  logic [4:0] conv_cnt;
  logic conv_busy;
  logic conv_q;
  logic [1:0] stall;

  // Interval/periodic timer of queue 2.
  logic [16:0] tmr;
  logic tmr_run;
  logic tmr_exp;
  logic [3:0] rate;
  assign rate = ctrl2[aqst_pkg::AQST_CTRL_RATE_LSB +: 4];
  assign tmr_run = tmr_mode && !mode_wr[1]
    && (mode[1] == aqst_pkg::AQST_MODE_TMR_CONT || armed[1]);
  always_comb begin
    int e;
    e = aqst_pkg::AQST_TMR_MIN_EXP + int'(rate);
    if (e > aqst_pkg::AQST_TMR_MAX_EXP) e = aqst_pkg::AQST_TMR_MAX_EXP;
    tmr_exp = conversion_clock_en && (tmr == 17'((64'h1 << e) - 64'h1));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !tmr_run) begin
      tmr <= 17'h00000;
    end else if (tmr_exp) begin
      tmr <= 17'h00000;
    end else if (conversion_clock_en) begin
      tmr <= tmr + 17'h00001;
    end
  end

  // Trigger per queue.
  logic [1:0] trig;
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      case (mode[q])
        aqst_pkg::AQST_MODE_SW_SINGLE:
          trig[q] = armed[q] && (!active[q] || paused[q]);
        aqst_pkg::AQST_MODE_EXT_SINGLE:
          trig[q] = armed[q] && ext_edge[q];
        aqst_pkg::AQST_MODE_TMR_SINGLE:
          trig[q] = q == 1 && armed[q] && tmr_exp;
        aqst_pkg::AQST_MODE_SW_CONT:
          trig[q] = (!active[q] || paused[q]) && stall == 2'h0;
        aqst_pkg::AQST_MODE_EXT_CONT:
          trig[q] = ext_edge[q];
        aqst_pkg::AQST_MODE_TMR_CONT:
          trig[q] = q == 1 && tmr_exp;
        default:
          trig[q] = 1'b0;
      endcase
    end
  end

  // A queue is busy while running, suspended or pending.
  logic [1:0] busy;
  assign busy = active & ~paused;
  logic q2_may_run;
  // Queue 1 in software continuous mode counts as always running, so queue 2 cannot
  // slip into the short stall after a queue 1 pause.
  assign q2_may_run = !busy[0] && !pend[0] && !trig[0]
    && mode[0] != aqst_pkg::AQST_MODE_SW_CONT;

  // Command word in force for each queue; pause in the same word loses to end.
  logic [1:0] at_eoq;
  logic [1:0] at_pause;
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      at_eoq[q] = ccw_word[q][5:0] == aqst_pkg::AQST_EOQ_CHANNEL
        || idx[q] >= ccw_len[q];
      at_pause[q] = ccw_word[q][aqst_pkg::AQST_CCW_PAUSE_BIT];
    end
  end
  logic [1:0] go;
  assign go[0] = busy[0] && !conv_busy;
  assign go[1] = busy[1] && !conv_busy && q2_may_run && !q2_susp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 2'h0;
      active <= 2'h0;
      paused <= 2'h0;
      pend <= 2'h0;
      q2_susp <= 1'b0;
      overrun <= 2'h0;
      pause_flag <= 2'h0;
      comp_flag <= 2'h0;
      idx[0] <= 6'h00;
      idx[1] <= 6'h00;
      conv_busy <= 1'b0;
      conv_q <= 1'b0;
      conv_cnt <= 5'h00;
      conv_start <= 2'h0;
      conv_abort <= 2'h0;
      conv_channel <= 6'h00;
      stall <= 2'h0;
    end else begin
      conv_start <= 2'h0;
      conv_abort <= 2'h0;
      // The stall runs from the end of the paused conversion, not from its start.
      if (stall != 2'h0 && conversion_clock_en && !conv_busy) stall <= stall - 2'h1;
      if (conv_busy && conversion_clock_en) begin
        conv_cnt <= conv_cnt - 5'h01;
        if (conv_cnt == 5'h01) conv_busy <= 1'b0;
      end
      // Queue 1 trigger preempts queue 2.
      if (trig[0] && conv_busy && conv_q) begin
        conv_busy <= 1'b0;
        conv_abort[1] <= 1'b1;
        q2_susp <= 1'b1;
      end
      if (q2_susp && q2_may_run && !trig[0]) q2_susp <= 1'b0;
      // Flags clear by writing one to the status register; a set in the same cycle wins.
      if (do_write && wsel == aqst_pkg::AQST_OFF_STATUS) begin
        overrun <= overrun & ~w_data[1:0];
        pause_flag <= pause_flag & ~w_data[3:2];
        comp_flag <= comp_flag & ~w_data[5:4];
      end
      for (int q = 0; q < 2; q++) begin
        if (mode_wr[q]) begin
          active[q] <= 1'b0;
          paused[q] <= 1'b0;
          pend[q] <= 1'b0;
          idx[q] <= 6'h00;
          armed[q] <= sse[q];
          if (conv_busy && conv_q == q[0]) begin
            conv_busy <= 1'b0;
            conv_abort[q] <= 1'b1;
          end
        end else begin
          if (sse[q] && !active[q]) armed[q] <= 1'b1;
          if (trig[q]) begin
            if (busy[q]) begin
              if (mode[q] == aqst_pkg::AQST_MODE_EXT_CONT
                  || mode[q] == aqst_pkg::AQST_MODE_TMR_CONT
                  || mode[q] == aqst_pkg::AQST_MODE_EXT_SINGLE
                  || mode[q] == aqst_pkg::AQST_MODE_TMR_SINGLE)
                overrun[q] <= 1'b1;
            end else if (paused[q]) begin
              paused[q] <= 1'b0;
            end else begin
              active[q] <= 1'b1;
              idx[q] <= 6'h00;
              if (q == 1 && !q2_may_run) pend[q] <= 1'b1;
            end
          end
          if (pend[q] && q2_may_run) pend[q] <= 1'b0;
          if (go[q] && !pend[q] && !(q == 1 && q2_susp)) begin
            if (at_eoq[q]) begin
              active[q] <= 1'b0;
              comp_flag[q] <= 1'b1;
              idx[q] <= 6'h00;
              if (mode[q] != aqst_pkg::AQST_MODE_SW_CONT
                  && mode[q] != aqst_pkg::AQST_MODE_EXT_CONT
                  && mode[q] != aqst_pkg::AQST_MODE_TMR_CONT)
                armed[q] <= 1'b0;
            end else begin
              conv_busy <= 1'b1;
              conv_q <= q[0];
              conv_cnt <= aqst_pkg::AQST_CONV_QCLKS;
              conv_start[q] <= 1'b1;
              conv_channel <= ccw_word[q][5:0];
              idx[q] <= idx[q] + 6'h01;
              if (at_pause[q]) begin
                paused[q] <= 1'b1;
                pause_flag[q] <= 1'b1;
                if (mode[q] == aqst_pkg::AQST_MODE_SW_CONT)
                  stall <= aqst_pkg::AQST_SWC_PAUSE_QCLKS;
              end
            end
          end
        end
      end
    end
  end

  // Queue state for reading.
  function automatic logic [2:0] qstate(input logic a, input logic p, input logic s,
                                       input logic pd);
    if (pd) return aqst_pkg::AQST_ST_PENDING;
    if (s) return aqst_pkg::AQST_ST_SUSPENDED;
    if (a && p) return aqst_pkg::AQST_ST_PAUSED;
    if (a) return aqst_pkg::AQST_ST_ACTIVE;
    return aqst_pkg::AQST_ST_IDLE;
  endfunction : qstate

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case ({s_axi_araddr[7:2], 2'h0})
        aqst_pkg::AQST_OFF_CTRL1:
          s_axi_rdata <= ctrl1 & ~(32'h1 << aqst_pkg::AQST_CTRL_SSE_BIT);
        aqst_pkg::AQST_OFF_CTRL2:
          s_axi_rdata <= ctrl2 & ~(32'h1 << aqst_pkg::AQST_CTRL_SSE_BIT);
        aqst_pkg::AQST_OFF_STATUS:
          s_axi_rdata <= {18'h00000, qstate(active[1], paused[1], q2_susp, pend[1]),
            qstate(active[0], paused[0], 1'b0, 1'b0), 2'h0, comp_flag, pause_flag, overrun};
        aqst_pkg::AQST_OFF_PRESC: s_axi_rdata <= {24'h000000, presc};
        aqst_pkg::AQST_OFF_CCW1: s_axi_rdata <= {18'h00000, ccw_len[0], 1'b0, ccw_word[0]};
        aqst_pkg::AQST_OFF_CCW2: s_axi_rdata <= {18'h00000, ccw_len[1], 1'b0, ccw_word[1]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ccw_index1 <= 6'h00;
      ccw_index2 <= 6'h00;
    end else begin
      ccw_index1 <= idx[0];
      ccw_index2 <= idx[1];
    end
  end

endmodule : aqst_top
`default_nettype wire

// ==== aqst_top_props.sv ====
// Port property checker for the queue scan and trigger controller.
`timescale 1ns/1ps
`default_nettype none
module aqst_top_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus responses.
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Conversion sequencer.
  input wire logic [1:0] conv_start,
  input wire logic [5:0] conv_channel,
  input wire logic [1:0] conv_abort
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before acceptance");
  bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before acceptance");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  end_code_skip_a: assert property (|conv_start |=> conv_channel != 6'h3F)
    else $error("end code channel converted");
  start_single_a: assert property (|conv_start |=> conv_start == 2'h0)
    else $error("conversion start not a single pulse");
  start_onehot_a: assert property ($onehot0(conv_start))
    else $error("both queues started at once");
  abort_single_a: assert property ($onehot0(conv_abort))
    else $error("both queues aborted at once");
endmodule : aqst_top_props
`default_nettype wire

// ==== aqst_trig_model.sv ====
// Trigger pin sources and conversion start observer beside the controller.
`timescale 1ns/1ps
`default_nettype none
module aqst_trig_model (
  // Clock.
  input wire logic aclk,
  // Trigger pins.
  output logic ext_trig1,
  output logic ext_trig2,
  // Sequencer strobes.
  input wire logic [1:0] conv_start,
  input wire logic [1:0] conv_abort
);
  int starts1 = 0;
  int starts2 = 0;
  int aborts = 0;
  initial begin
    ext_trig1 = 1'b0;
    ext_trig2 = 1'b0;
  end
  always @(posedge aclk) begin
    starts1 += int'(conv_start[0]);
    starts2 += int'(conv_start[1]);
    aborts += int'(|conv_abort);
  end
  // Each level is held well past the synchroniser depth so no edge is lost.
  task automatic pulse(input int q);
    @(posedge aclk);
    if (q == 1) ext_trig1 <= 1'b1;
    else ext_trig2 <= 1'b1;
    repeat (8) @(posedge aclk);
    if (q == 1) ext_trig1 <= 1'b0;
    else ext_trig2 <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : pulse
endmodule : aqst_trig_model
`default_nettype wire

// ==== adc_queue_scan_trigger_test.sv ====
// Self-checking testbench of the queue scan and trigger controller.
`timescale 1ns/1ps
`default_nettype none
module adc_queue_scan_trigger_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, trig1, trig2;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, conv_start, conv_abort;
  logic [5:0] conv_channel;
  logic [3:0] wstrb;
  logic [5:0] idx1, idx2;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  aqst_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trig1(trig1),
    .ext_trig2(trig2), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_abort(conv_abort), .ccw_index1(idx1), .ccw_index2(idx2));
  aqst_trig_model trig_u (.aclk(aclk), .ext_trig1(trig1), .ext_trig2(trig2),
    .conv_start(conv_start), .conv_abort(conv_abort));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // The ceiling is several times the expected run length.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  // Ready is looked at just before the edge, so the handshake edge is known exactly.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    while (!b_ok) begin
      @(negedge aclk);
      b_ok = bvalid;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok) begin
      @(negedge aclk);
      ok = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : axi_read
  task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_val(what, exp, d & m);
  endtask : check_reg
  task automatic test_sw_single();
    int s;
    logic [31:0] d;
    logic [1:0] r;
    axi_read(8'h20, d, r);
    check_val("unmapped resp", 32'h2, {30'h0, r});
    axi_write(8'h10, 32'h0000_0345);
    axi_write(8'h08, 32'h0000_003F);
    s = trig_u.starts1;
    axi_write(8'h00, 32'h0000_0011);
    axi_write(8'h00, 32'h0000_0011);
    check_reg("ctrl1 enable read", 8'h00, 32'h10, 32'h0);
    repeat (400) @(posedge aclk);
    check_val("q1 single pass", s + 3, trig_u.starts1);
    check_reg("q1 overrun", 8'h08, 32'h1, 32'h0);
    check_reg("q1 pause flag", 8'h08, 32'h4, 32'h4);
    check_val("q1 channel", 32'h5, {26'h0, conv_channel});
    check_val("q1 index at end", 32'h0, {26'h0, idx1});
    axi_write(8'h00, 32'h0);
    $display("test sw_single done");
  endtask : test_sw_single
  task automatic test_end_code();
    int s;
    axi_write(8'h10, 32'h0000_033F);
    axi_write(8'h08, 32'h0000_003F);
    s = trig_u.starts1;
    axi_write(8'h00, 32'h0000_0011);
    repeat (100) @(posedge aclk);
    check_val("q1 end code starts", s, trig_u.starts1);
    check_reg("q1 complete flag", 8'h08, 32'h10, 32'h10);
    axi_write(8'h00, 32'h0);
    $display("test end_code done");
  endtask : test_end_code
  task automatic test_ext_single();
    int s;
    axi_write(8'h14, 32'h0000_0207);
    axi_write(8'h04, 32'h0000_000A);
    s = trig_u.starts2;
    trig_u.pulse(2);
    repeat (150) @(posedge aclk);
    check_val("q2 disabled edge", s, trig_u.starts2);
    axi_write(8'h04, 32'h0000_001A);
    trig_u.pulse(2);
    repeat (200) @(posedge aclk);
    check_val("q2 edge pass", s + 2, trig_u.starts2);
    trig_u.pulse(2);
    repeat (200) @(posedge aclk);
    check_val("q2 edge no rerun", s + 2, trig_u.starts2);
    check_reg("ctrl2 enable read", 8'h04, 32'h10, 32'h0);
    axi_write(8'h04, 32'h0);
    $display("test ext_single done");
  endtask : test_ext_single
  task automatic test_ext_cont();
    int s;
    axi_write(8'h14, 32'h0000_0207);
    axi_write(8'h08, 32'h0000_003F);
    s = trig_u.starts2;
    axi_write(8'h04, 32'h0000_0005);
    trig_u.pulse(2);
    trig_u.pulse(2);
    check_val("q2 index mid scan", 32'h1, {26'h0, idx2});
    repeat (200) @(posedge aclk);
    check_val("q2 cont pass", s + 2, trig_u.starts2);
    check_reg("q2 overrun", 8'h08, 32'h2, 32'h2);
    trig_u.pulse(2);
    repeat (200) @(posedge aclk);
    check_val("q2 cont rerun", s + 4, trig_u.starts2);
    check_val("q2 index restart", 32'h0, {26'h0, idx2});
    axi_write(8'h04, 32'h0);
    $display("test ext_cont done");
  endtask : test_ext_cont
  task automatic test_sw_cont();
    int s1, s2, a;
    axi_write(8'h10, 32'h0000_0245);
    axi_write(8'h14, 32'h0000_0107);
    axi_write(8'h08, 32'h0000_003F);
    axi_write(8'h04, 32'h0000_000D);
    s1 = trig_u.starts1;
    s2 = trig_u.starts2;
    axi_write(8'h00, 32'h0000_0004);
    repeat (300) @(posedge aclk);
    trig_u.pulse(2);
    repeat (300) @(posedge aclk);
    check_val("q1 keeps running", 32'h1, {31'h0, trig_u.starts1 - s1 >= 10});
    check_val("q2 starved", s2, trig_u.starts2);
    check_reg("q1 overrun", 8'h08, 32'h1, 32'h0);
    // Change the mode just after a start so that a conversion is surely under way.
    while (!conv_start[0]) @(posedge aclk);
    a = trig_u.aborts;
    axi_write(8'h00, 32'h0);
    repeat (10) @(posedge aclk);
    check_val("q1 mode change abort", 32'h1, {31'h0, trig_u.aborts > a});
    axi_write(8'h04, 32'h0);
    repeat (100) @(posedge aclk);
    $display("test sw_cont done");
  endtask : test_sw_cont
  task automatic test_timer();
    int s;
    axi_write(8'h14, 32'h0000_0107);
    s = trig_u.starts2;
    axi_write(8'h04, 32'h0000_0006);
    repeat (400) @(posedge aclk);
    check_val("q2 periodic first", s + 1, trig_u.starts2);
    repeat (250) @(posedge aclk);
    check_val("q2 periodic second", s + 2, trig_u.starts2);
    axi_write(8'h04, 32'h0);
    s = trig_u.starts2;
    axi_write(8'h04, 32'h0000_0013);
    repeat (400) @(posedge aclk);
    check_val("q2 interval pass", s + 1, trig_u.starts2);
    repeat (700) @(posedge aclk);
    check_val("q2 interval stops", s + 1, trig_u.starts2);
    axi_write(8'h04, 32'h0);
    $display("test timer done");
  endtask : test_timer
  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Two system clocks per conversion clock keep conversions and timer intervals short.
    axi_write(8'h0C, 32'h1);
    test_sw_single();
    test_end_code();
    test_ext_single();
    test_ext_cont();
    test_sw_cont();
    test_timer();
    print_verdict();
  end
endmodule : adc_queue_scan_trigger_test
bind aqst_top aqst_top_props chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_abort(conv_abort));
`default_nettype wire
